// [verilog/mlf_lock_fault_settings.sv]
// Purpose: Lock fault settings register with lock reaction.
// Assumes: AXI4-Lite slave, one clock, measurements on the same clock.
// Notes:   Status bits are sticky and clear when the status is read.
// Functional notes
// - Settings word at index 92h, resets zero.
// - Bit 30 enables overspeed lock detector.
// - Bit 29 enables back-EMF lock detector.
// - Bit 28 enables motor-absent lock detector.
// - Bits 27-25 pick overspeed 130-200 percent.
// - Bits 24-22 pick back-EMF 10-80 percent.
// - Bits 21-19 pick motor-absent current limit.
// - Lock reaction: latch, auto retry, report, off.
// - Retry limit codes: unlimited, 2..20 attempts.
`timescale 1ns/1ns
`default_nettype none
`include "mlf_defines.svh"

module mlf_lock_fault_settings #(
  // Clock cycles per millisecond; shorten for simulation
  parameter logic [23:0] CYC_PER_MS = 24'(`MLF_CYC_PER_MS)
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  // AXI4-Lite write address
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [11:0]        awaddr,
  // AXI4-Lite write data
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  // AXI4-Lite write response
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  // AXI4-Lite read address
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [11:0]        araddr,
  // AXI4-Lite read data
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  // Measurements from the control loop
  input  wire mlf_pkg::mlf_meas_t meas,
  // Fault reporting and output stage
  output logic                    lockFault,
  output logic                    faultPinNOut,
  output logic                    faultPinNOe,
  output logic                    driveHold,
  output var  mlf_pkg::mlf_drive_t driveMode,
  output logic                    irq
);

  // Retry limit code to attempt count, zero means unlimited
  function automatic logic [4:0] retryLimit(input logic [2:0] c);
    case (c)
      3'h1:    retryLimit = `MLF_RETRY_LIM_1;
      3'h2:    retryLimit = `MLF_RETRY_LIM_2;
      3'h3:    retryLimit = `MLF_RETRY_LIM_3;
      3'h4:    retryLimit = `MLF_RETRY_LIM_4;
      3'h5:    retryLimit = `MLF_RETRY_LIM_5;
      3'h6:    retryLimit = `MLF_RETRY_LIM_6;
      3'h7:    retryLimit = `MLF_RETRY_LIM_7;
      default: retryLimit = 5'h00;
    endcase
  endfunction : retryLimit

  // Merge a write into a word under its byte strobes
  function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  stb);
    applyStrb = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        applyStrb[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : applyStrb

  mlf_pkg::mlf_state_t q;        // Current state
  mlf_pkg::mlf_state_t d;        // Next state
  mlf_pkg::mlf_lock_t  hitsRaw;  // Detector hits before the enables
  mlf_pkg::mlf_lock_t  lockNow;  // Hits of enabled detectors only
  logic                anyLock;  // Some enabled detector sees a lock
  logic [3:0]          reactSel; // Lock reaction select
  logic [4:0]          retryLim; // Allowed retries, zero unlimited
  logic                timerBusy;
  logic                timerDone;

  // Threshold compares live in their own module
  mlf_lock_detect u_detect (
    .clk        (clk),
    .resetn     (resetn),
    .meas       (meas),
    .spdCode    (q.settings[`MLF_SPD_THR_LSB +: 3]),
    .bemfCode   (q.settings[`MLF_BEMF_THR_LSB +: 3]),
    .absentCode (q.settings[`MLF_ABSENT_THR_LSB +: 3]),
    .hits       (hitsRaw)
  );

  // Delay before each automatic fault clear
  mlf_retry_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .start  (q.timerStart),
    .code   (q.reaction[`MLF_RETRY_DLY_LSB +: 4]),
    .busy   (timerBusy),
    .done   (timerDone)
  );

  // Enables gate each detector; a disabled one cannot fault
  assign lockNow.spd    = hitsRaw.spd & q.settings[`MLF_SPD_EN_BIT];
  assign lockNow.bemf   = hitsRaw.bemf & q.settings[`MLF_BEMF_EN_BIT];
  assign lockNow.absent = hitsRaw.absent &
                          q.settings[`MLF_ABSENT_EN_BIT];
  assign anyLock        = |lockNow;

  assign reactSel = q.reaction[`MLF_REACT_SEL_LSB +: 4];
  assign retryLim = retryLimit(q.settings[`MLF_RETRY_LIM_LSB +: 3]);

  // Next-state logic: bus slave, registers, reaction machine
  always_comb begin
    logic        wrGo;     // Address and data both present
    logic [9:0]  wIdx;     // Word index of the write
    logic [31:0] wDat;     // Write data
    logic [3:0]  wStb;     // Write strobes
    logic [31:0] merged;   // Strobed write value
    logic        clrPulse; // Software clears a latched fault
    logic        rdClr;    // Status read this cycle
    logic [9:0]  rIdx;     // Word index of the read
    logic [4:0]  evt;      // Status events this cycle
    d            = q;
    d.timerStart = 1'b0;
    clrPulse     = 1'b0;
    rdClr        = 1'b0;
    evt          = 5'h00;
    merged       = 32'h0000_0000;
    rIdx         = araddr[11:2];
    wIdx = q.awHave ? q.awIdx : awaddr[11:2];
    wDat = q.wHave ? q.wData : wdata;
    wStb = q.wHave ? q.wStrb : wstrb;
    wrGo = (q.awHave || (awvalid && awready)) &&
           (q.wHave || (wvalid && wready)) && !q.bValid;

    // Write address and data may arrive in either order
    if (awvalid && awready) begin
      d.awHave = 1'b1;
      d.awIdx  = awaddr[11:2];
    end
    if (wvalid && wready) begin
      d.wHave = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end

    // Commit the write once both halves are in
    if (wrGo) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = `MLF_RESP_OKAY;
      if (wIdx == `MLF_IDX_SETTINGS) begin
        d.settings = applyStrb(q.settings, wDat, wStb);
      end else if (wIdx == `MLF_IDX_REACTION) begin
        // Clear bit is a strobe; it never reads back as one
        d.reaction = applyStrb(q.reaction, wDat, wStb);
        d.reaction[`MLF_FAULT_CLR_BIT] = 1'b0;
        clrPulse = wStb[3] & wDat[`MLF_FAULT_CLR_BIT];
      end else if (wIdx == `MLF_IDX_MASK) begin
        merged = applyStrb({27'h0, q.mask}, wDat, wStb);
        d.mask = merged[4:0];
      end else if (wIdx == `MLF_IDX_STATUS) begin
        // Status clears only by reading; writes are accepted
        d.bResp = `MLF_RESP_OKAY;
      end else begin
        // Unmapped address
        d.bResp = `MLF_RESP_SLVERR;
      end
    end else if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end

    // Read: one outstanding, answered the cycle after acceptance
    if (arvalid && arready) begin
      d.rValid = 1'b1;
      d.rResp  = `MLF_RESP_OKAY;
      if (rIdx == `MLF_IDX_SETTINGS) begin
        d.rData = q.settings;
      end else if (rIdx == `MLF_IDX_REACTION) begin
        d.rData = q.reaction;
      end else if (rIdx == `MLF_IDX_STATUS) begin
        d.rData = {27'h0, q.status};
        rdClr   = 1'b1;
      end else if (rIdx == `MLF_IDX_MASK) begin
        d.rData = {27'h0, q.mask};
      end else begin
        d.rData = 32'h0000_0000;
        d.rResp = `MLF_RESP_SLVERR;
      end
    end else if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end

    // Detector events; only enabled detectors reach status
    evt[`MLF_ST_SPD]    = lockNow.spd;
    evt[`MLF_ST_BEMF]   = lockNow.bemf;
    evt[`MLF_ST_ABSENT] = lockNow.absent;

    // Lock reaction machine
    unique case (q.fsm)
      mlf_pkg::MLF_IDLE: begin
        if (anyLock) begin
          if (reactSel < `MLF_SEL_RETRY_LO) begin
            // Latched fault with the chosen output action
            d.fsm = mlf_pkg::MLF_LATCHED;
            evt[`MLF_ST_LATCH] = 1'b1;
          end else if (reactSel < `MLF_SEL_REPORT) begin
            if (retryLim != 5'h00 && q.retryCnt >= retryLim) begin
              // Retries used up: fault latches
              d.fsm = mlf_pkg::MLF_LATCHED;
              evt[`MLF_ST_LATCH] = 1'b1;
            end else begin
              // Hold off, then clear automatically
              d.fsm        = mlf_pkg::MLF_RETRY;
              d.timerStart = 1'b1;
              if (retryLim != 5'h00) begin
                d.retryCnt = q.retryCnt + 5'h01;
              end
            end
          end else if (reactSel == `MLF_SEL_REPORT) begin
            // Report only: pin active, output stage untouched
            d.fsm = mlf_pkg::MLF_REPORT;
          end
        end
      end
      mlf_pkg::MLF_RETRY: begin
        if (timerDone) begin
          d.fsm = mlf_pkg::MLF_IDLE;
          evt[`MLF_ST_RETRY] = 1'b1;
        end
      end
      mlf_pkg::MLF_LATCHED: begin
        // Only software releases a latched fault
        if (clrPulse) begin
          d.fsm      = mlf_pkg::MLF_IDLE;
          d.retryCnt = 5'h00;
        end
      end
      mlf_pkg::MLF_REPORT: begin
        if (!anyLock) begin
          d.fsm = mlf_pkg::MLF_IDLE;
        end
      end
      default: begin
        // Recover from an illegal code
        d.fsm = mlf_pkg::MLF_IDLE;
      end
    endcase

    // Sticky status: a new event wins over the read clear
    d.status = (q.status & ~(rdClr ? q.status : 5'h00)) | evt;
  end

  // State register; everything resets to a constant
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q          <= '0;
      q.settings <= `MLF_SETTINGS_RST;
      q.reaction <= `MLF_REACTION_RST;
      q.status   <= `MLF_STATUS_RST;
      q.mask     <= `MLF_MASK_RST;
      q.fsm      <= mlf_pkg::MLF_IDLE;
    end else begin
      q <= d;
    end
  end

  // Bus handshakes: one write and one read in flight
  assign awready = !q.awHave && !q.bValid;
  assign wready  = !q.wHave && !q.bValid;
  assign bvalid  = q.bValid;
  assign bresp   = q.bResp;
  assign arready = !q.rValid;
  assign rvalid  = q.rValid;
  assign rdata   = q.rData;
  assign rresp   = q.rResp;

  // Fault outputs; the pin is open-drain, so it only pulls low
  assign lockFault    = q.fsm != mlf_pkg::MLF_IDLE;
  assign faultPinNOut = 1'b0;
  assign faultPinNOe  = q.fsm != mlf_pkg::MLF_IDLE;
  assign driveHold    = q.fsm == mlf_pkg::MLF_LATCHED ||
                        q.fsm == mlf_pkg::MLF_RETRY;
  assign driveMode    = mlf_pkg::mlf_drive_t'(reactSel[1:0]);
  assign irq          = |(q.status & q.mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  settings_reset_a: assert property (
    !$past(resetn) |-> q.settings == 32'h0000_0000)
    else $error("settings not zero after reset");

  spd_gate_a: assert property (
    (!q.settings[30] && !q.status[0]) |=> !q.status[0])
    else $error("disabled overspeed detector set status");

  bemf_gate_a: assert property (
    (!q.settings[29] && !q.status[1]) |=> !q.status[1])
    else $error("disabled back-EMF detector set status");

  absent_gate_a: assert property (
    (!q.settings[28] && !q.status[2]) |=> !q.status[2])
    else $error("disabled motor-absent detector set status");

  no_fault_off_a: assert property (
    (q.settings[30:28] == 3'h0 && q.fsm == mlf_pkg::MLF_IDLE)
    |=> q.fsm == mlf_pkg::MLF_IDLE)
    else $error("fault raised with all detectors disabled");

  latch_mode_a: assert property (
    (q.fsm == mlf_pkg::MLF_IDLE && anyLock && reactSel < 4'h4)
    |=> (q.fsm == mlf_pkg::MLF_LATCHED && faultPinNOe && q.status[3]))
    else $error("latched lock mode did not latch the fault");

  retry_limit_a: assert property (
    (q.fsm == mlf_pkg::MLF_RETRY && retryLim != 5'h00)
    |-> q.retryCnt <= retryLim)
    else $error("retry count above the allowed attempts");

  retry_timer_a: assert property (
    (q.fsm == mlf_pkg::MLF_RETRY && !q.timerStart)
    |-> (timerBusy || timerDone))
    else $error("retry wait without a running timer");

  bresp_hold_a: assert property (
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before bready");

endmodule : mlf_lock_fault_settings
`default_nettype wire

// [shared/mlf_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts
//          for the motor lock fault settings block.
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz block clock.
// Notes:   Indices are word indices; byte address is index times four.
`ifndef MLF_DEFINES_SVH
`define MLF_DEFINES_SVH

// Register indices
`define MLF_IDX_SETTINGS   10'h092
`define MLF_IDX_REACTION   10'h093
`define MLF_IDX_STATUS     10'h094
`define MLF_IDX_MASK       10'h095

// Reset values
`define MLF_SETTINGS_RST   32'h0000_0000
`define MLF_REACTION_RST   32'h0000_0000
`define MLF_STATUS_RST     5'h00
`define MLF_MASK_RST       5'h00

// Settings register fields
`define MLF_PARITY_BIT     31
`define MLF_SPD_EN_BIT     30
`define MLF_BEMF_EN_BIT    29
`define MLF_ABSENT_EN_BIT  28
`define MLF_SPD_THR_LSB    25
`define MLF_BEMF_THR_LSB   22
`define MLF_ABSENT_THR_LSB 19
`define MLF_RETRY_LIM_LSB  0

// Reaction register fields
`define MLF_REACT_SEL_LSB  3
`define MLF_RETRY_DLY_LSB  7
`define MLF_FAULT_CLR_BIT  31

// Reaction select boundaries
`define MLF_SEL_RETRY_LO   4'h4
`define MLF_SEL_REPORT     4'h8

// Status and mask bit positions
`define MLF_ST_SPD         0
`define MLF_ST_BEMF        1
`define MLF_ST_ABSENT      2
`define MLF_ST_LATCH       3
`define MLF_ST_RETRY       4

// Threshold tables
`define MLF_PCT_FULL       8'd100
`define MLF_PCT_STEP       8'd10
`define MLF_SPD_PCT_BASE   8'd130
`define MLF_BEMF_PCT_BASE  8'd10
`define MLF_ABSENT_MA_0    11'd50
`define MLF_ABSENT_MA_1    11'd75
`define MLF_ABSENT_MA_2    11'd100
`define MLF_ABSENT_MA_3    11'd125
`define MLF_ABSENT_MA_4    11'd250
`define MLF_ABSENT_MA_5    11'd500
`define MLF_ABSENT_MA_6    11'd750
`define MLF_ABSENT_MA_7    11'd1000

// Retry attempt limits, code 0 means unlimited
`define MLF_RETRY_LIM_1    5'd2
`define MLF_RETRY_LIM_2    5'd3
`define MLF_RETRY_LIM_3    5'd5
`define MLF_RETRY_LIM_4    5'd7
`define MLF_RETRY_LIM_5    5'd10
`define MLF_RETRY_LIM_6    5'd15
`define MLF_RETRY_LIM_7    5'd20

// Timing
`define MLF_CLK_PERIOD_NS  10
`define MLF_MS_NS          1000000
`define MLF_CYC_PER_MS     (`MLF_MS_NS / `MLF_CLK_PERIOD_NS)
`define MLF_RETRY0_MS      14'd100
`define MLF_RETRY1_MS      14'd500
`define MLF_RETRY_STEP_MS  14'd1000

// Bus responses
`define MLF_RESP_OKAY      2'b00
`define MLF_RESP_SLVERR    2'b10

`endif

// [shared/mlf_pkg.sv]
// Purpose: Types for the motor lock fault settings block.
// Assumes: All measurements are produced on the block clock.
// Notes:   Numeric constants live in mlf_defines.svh.
package mlf_pkg;

  // Reaction state, one-hot
  typedef enum logic [3:0] {
    MLF_IDLE    = 4'h1,
    MLF_RETRY   = 4'h2,
    MLF_LATCHED = 4'h4,
    MLF_REPORT  = 4'h8
  } mlf_fsm_t;

  // Output stage action while a fault holds
  typedef enum logic [1:0] {
    MLF_DRV_TRISTATE = 2'h0,
    MLF_DRV_RECIRC   = 2'h1,
    MLF_DRV_HS_BRAKE = 2'h2,
    MLF_DRV_LS_BRAKE = 2'h3
  } mlf_drive_t;

  // One flag per lock detector
  typedef struct packed {
    logic absent;
    logic bemf;
    logic spd;
  } mlf_lock_t;

  // Measurements from the control loop
  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] maxSpeed;
    logic [15:0] bemf;
    logic [15:0] bemfExpected;
    logic [15:0] currentMa;
  } mlf_meas_t;

  // Retry delay timer state
  typedef struct packed {
    logic        busy;
    logic [23:0] pre;
    logic [13:0] ms;
    logic        done;
  } mlf_timer_t;

  // Top-level state: registers, bus channels, reaction machine
  typedef struct packed {
    logic [31:0] settings;
    logic [31:0] reaction;
    logic [4:0]  status;
    logic [4:0]  mask;
    logic        awHave;
    logic [9:0]  awIdx;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    mlf_fsm_t    fsm;
    logic [4:0]  retryCnt;
    logic        timerStart;
  } mlf_state_t;

endpackage : mlf_pkg

// [verilog/mlf_lock_detect.sv]
// Purpose: Compare measurements against the three lock thresholds.
// Assumes: Measurements are on clk; codes come from the settings word.
// Notes:   Raw hits, not yet gated by the enables; one cycle latency.
`timescale 1ns/1ns
`default_nettype none
`include "mlf_defines.svh"

module mlf_lock_detect (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire mlf_pkg::mlf_meas_t meas,
  input  wire logic [2:0]         spdCode,
  input  wire logic [2:0]         bemfCode,
  input  wire logic [2:0]         absentCode,
  output var  mlf_pkg::mlf_lock_t hits
);

  // Percentage for a code: base plus ten per step
  function automatic logic [7:0] pctOf(input logic [7:0] base,
                                       input logic [2:0] code);
    pctOf = base + `MLF_PCT_STEP * {5'h00, code};
  endfunction : pctOf

  // Product kept at full width so no term overflows
  function automatic logic [23:0] scale(input logic [15:0] v,
                                        input logic [7:0]  p);
    scale = {8'h00, v} * {16'h0000, p};
  endfunction : scale

  // Motor-absent current limit in milliamperes
  function automatic logic [10:0] absentMa(input logic [2:0] code);
    case (code)
      3'h0:    absentMa = `MLF_ABSENT_MA_0;
      3'h1:    absentMa = `MLF_ABSENT_MA_1;
      3'h2:    absentMa = `MLF_ABSENT_MA_2;
      3'h3:    absentMa = `MLF_ABSENT_MA_3;
      3'h4:    absentMa = `MLF_ABSENT_MA_4;
      3'h5:    absentMa = `MLF_ABSENT_MA_5;
      3'h6:    absentMa = `MLF_ABSENT_MA_6;
      default: absentMa = `MLF_ABSENT_MA_7;
    endcase
  endfunction : absentMa

  mlf_pkg::mlf_lock_t d;  // Next hits

  // Threshold compares; percentages avoid any divider
  always_comb begin
    d.spd    = scale(meas.speed, `MLF_PCT_FULL) >
               scale(meas.maxSpeed, pctOf(`MLF_SPD_PCT_BASE, spdCode));
    d.bemf   = scale(meas.bemf, `MLF_PCT_FULL) <
               scale(meas.bemfExpected,
                     pctOf(`MLF_BEMF_PCT_BASE, bemfCode));
    d.absent = meas.currentMa < {5'h00, absentMa(absentCode)};
  end

  // Register the hits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hits <= '0;
    end else begin
      hits <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  spd_top_code_a: assert property (
    (spdCode == 3'h7 && 24'(meas.speed) * 24'd100 >
     24'(meas.maxSpeed) * 24'd200) |=> hits.spd)
    else $error("overspeed not flagged above 200 percent");

  bemf_low_code_a: assert property (
    (bemfCode == 3'h0 && 24'(meas.bemf) * 24'd100 >=
     24'(meas.bemfExpected) * 24'd10) |=> !hits.bemf)
    else $error("back-EMF flagged at or above 10 percent");

  absent_mid_code_a: assert property (
    (absentCode == 3'h4) |=> (hits.absent == ($past(meas.currentMa) < 16'd250)))
    else $error("motor absent flag wrong for 0.25 A limit");

endmodule : mlf_lock_detect
`default_nettype wire

// [verilog/mlf_retry_timer.sv]
// Purpose: Count the retry delay before an automatic fault clear.
// Assumes: start is a one-cycle pulse on clk.
// Notes:   A millisecond prescaler keeps the counters short.
`timescale 1ns/1ns
`default_nettype none
`include "mlf_defines.svh"

module mlf_retry_timer #(
  parameter logic [23:0] CYC_PER_MS = 24'(`MLF_CYC_PER_MS)
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [3:0] code,
  output logic            busy,
  output logic            done
);

  // Delay in milliseconds: 100, 500, then whole seconds
  function automatic logic [13:0] delayMs(input logic [3:0] c);
    if (c == 4'h0) begin
      delayMs = `MLF_RETRY0_MS;
    end else if (c == 4'h1) begin
      delayMs = `MLF_RETRY1_MS;
    end else begin
      delayMs = 14'(`MLF_RETRY_STEP_MS * 14'(c - 4'h1));
    end
  endfunction : delayMs

  mlf_pkg::mlf_timer_t q;  // Current state
  mlf_pkg::mlf_timer_t d;  // Next state

  // Prescale to milliseconds, then count the delay down
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      d.pre  = '0;
      d.ms   = delayMs(code);
    end else if (q.busy) begin
      if (q.pre == CYC_PER_MS - 24'h1) begin
        d.pre = '0;
        if (q.ms == 14'h1) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end else begin
          d.ms = q.ms - 14'h1;
        end
      end else begin
        d.pre = q.pre + 24'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  done_one_cycle_a: assert property (done |=> !done)
    else $error("retry done held longer than one cycle");

  busy_nonzero_a: assert property (busy |-> q.ms != 14'h0)
    else $error("retry timer busy with zero delay left");

endmodule : mlf_retry_timer
`default_nettype wire

// [verif/tb_mlf_lock_fault_settings.sv]
// Purpose: Self-checking bench for the lock fault settings block.
// Assumes: Bench acts as AXI4-Lite master; 100 MHz clock.
// Notes:   Prescaler shortened; lock reaction at latch (select 0) except in the retry and report test.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk = 0, resetn = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        lockFault, faultPinNOe, irq, driveHold, faultPinNOut;
  logic [1:0]  driveMode;
  int          failures = 0, n_checks = 0;
  // Quiet measurements: no detector can trip on these
  mlf_pkg::mlf_meas_t idle = {16'h0000, 16'h0064, 16'h0064, 16'h0064,
                              16'h07d0};
  mlf_pkg::mlf_meas_t meas = idle;
  int          tbl [8] = '{50, 75, 100, 125, 250, 500, 750, 1000};
  always #5 clk = ~clk;
  // Short millisecond so the run stays brief
  mlf_lock_fault_settings #(.CYC_PER_MS(24'h00000a)) dut (.clk, .resetn,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .meas, .lockFault, .faultPinNOut, .faultPinNOe, .driveHold,
    .driveMode, .irq);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rs = bresp;
    bready <= 0;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd = rdata; rs = rresp;
    rready <= 0;
  endtask : rdr
  function automatic mlf_pkg::mlf_meas_t m(input logic [15:0] s, b, i);
    m = {s, 16'h0064, b, 16'h0064, i};
  endfunction : m
  // Quiet level, then a breach; latched fault is cleared afterwards
  task automatic try(input logic [31:0] s, input mlf_pkg::mlf_meas_t ok,
                     input mlf_pkg::mlf_meas_t bad, input logic hit);
    wr(12'h248, s);
    meas <= ok;
    repeat (4) @(posedge clk);
    chk(lockFault, 0);
    meas <= bad;
    repeat (4) @(posedge clk);
    chk(lockFault, hit);
    chk(faultPinNOe, hit);
    meas <= idle;
    repeat (4) @(posedge clk);
    wr(12'h24c, 32'h8000_0000);
    rdr(12'h250);
    chk(lockFault, 0);
  endtask : try
  // Retry mode: two automatic clears, then the limit latches; then report
  task automatic retry_report;
    wr(12'h24c, 32'h8000_0028);
    wr(12'h248, 32'h4000_0001);
    rdr(12'h250);
    for (int k = 0; k < 3; k++) begin
      meas <= m(200, 100, 2000);
      repeat (4) @(posedge clk);
      chk(driveHold, 1);
      chk(driveMode, 1);
      meas <= idle;
      repeat (1010) @(posedge clk);
      chk(lockFault, k == 2);
    end
    rdr(12'h250);
    chk(rd & 32'h18, 32'h18);
    wr(12'h24c, 32'h8000_0040);
    meas <= m(200, 100, 2000);
    repeat (4) @(posedge clk);
    chk({lockFault, driveHold, faultPinNOut}, 3'b100);
    meas <= idle;
    repeat (4) @(posedge clk);
    chk(lockFault, 0);
  endtask : retry_report
  task complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1;
    rdr(12'h248);
    chk(rd, 0);
    chk(rs, 2'b00);
    rdr(12'h000);
    chk(rs, 2'b10);
    wr(12'h248, 32'hffff_ffff);
    rdr(12'h248);
    chk(rd, 32'hffff_ffff);
    wr(12'h254, 32'h1);
    // Every threshold code of every detector, at and past its edge
    for (int c = 0; c < 8; c++) begin
      try(32'h4000_0000 | c << 25, m(130 + 10 * c, 100, 2000),
          m(131 + 10 * c, 100, 2000), 1);
      try(32'h2000_0000 | c << 22, m(0, 10 + 10 * c, 2000),
          m(0, 9 + 10 * c, 2000), 1);
      try(32'h1000_0000 | c << 19, m(0, 100, tbl[c]),
          m(0, 100, tbl[c] - 1), 1);
    end
    try(32'h0fff_ffff, idle, m(400, 0, 0), 0);
    // Masked overspeed raises the interrupt until status is read
    wr(12'h248, 32'h4000_0000);
    meas <= m(200, 100, 2000);
    repeat (4) @(posedge clk);
    chk(irq, 1);
    meas <= idle;
    repeat (4) @(posedge clk);
    rdr(12'h250);
    chk(rd & 32'h1, 32'h1);
    rdr(12'h250);
    chk(irq, 0);
    retry_report;
    complete_run;
  end
endmodule : tb
`default_nettype wire
